/* hw/nco_serial_command_core.sv */
// Oscillator core: phase accumulator, phase offsets, cosine lookup and serial command decode.
// Assumes the serial link and select pins are synchronous to mclk and software uses Avalon-MM.
//
// Notes on behaviour
// [R01] 32-bit accumulator wraps over one cycle.
// [R02] Full cycle maps onto all 32 bits.
// [R03] Step comes from word a or b.
// [R04] Word switch never reloads the accumulator.
// [R05] One of four offsets added at top.
// [R06] Upper 12 phase bits address the table.
// [R07] Table gives 10-bit amplitude codes.
// [R08] Each framed write carries sixteen bits.
// [R09] Bits taken on falling serial clock edges.
// [R10] Host raises frame sync after sixteen edges.
// [R11] Serial clock may run or park.
// [R12] Word is command, address, data, MSB first.
// [R13] Code 0000 writes full phase offset.
// [R14] Code 0001 loads defer byte only.
// [R15] Code 0010 writes half frequency word.
// [R16] Code 0011 loads defer byte only.
// [R17] Code 0100 loads phase choice bits.
// [R18] Code 0101 loads frequency choice bit.
// [R19] Code 0110 loads all choice bits.
// [R20] Host never sends reserved code 0111.
// [R21] Source bit picks pins or bits.
// [R22] Updates follow the sixteenth falling edge.
// [R23] Select pins sampled on rising mclk.
// [R24] Accumulator adds step every clock.
// [R25] Unused fields of select commands ignored.
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module nco_serial_command_core
  import nco_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  input  wire logic        serial_clk_i,
  input  wire logic        frame_sync_n_i,
  input  wire logic        serial_data_in_i,
  input  wire logic        freq_word_choose_i,
  input  wire logic        phase_choose_lo_i,
  input  wire logic        phase_choose_hi_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic      [9:0]  dac_code_o
);

  core_state_t  state;
  core_state_t  next_state;
  serial_word_t word;
  logic         word_valid;
  logic [15:0]  word_bits;
  logic [15:0]  merged;
  logic         freq_pick;
  logic [1:0]   phase_pick;
  logic [11:0]  table_addr;
  logic         bus_req;
  logic         bus_write;

  serial_word_rx u_rx
  (
    .mclk_i           (mclk_i),
    .reset_n_i        (reset_n_i),
    .serial_clk_i     (serial_clk_i),
    .frame_sync_n_i   (frame_sync_n_i),
    .serial_data_in_i (serial_data_in_i),
    .word_o           (word),
    .word_valid_o     (word_valid)
  );

  assign word_bits = 16'(word);

  // The defer register keeps both bytes; A0 chooses which byte a write lands in.
  always_comb
  begin
    merged = state.defer;
    if (word.addr[0])
      merged[15:8] = word.data;
    else
      merged[7:0] = word.data;
  end

  // [R21] source bit selects
  // Pins are used from their registered copy, so a change lands on a clean edge.
  always_comb
  begin
    if (state.choose_source)
    begin
      freq_pick  = state.freq_bit;
      phase_pick = state.phase_bits;
    end
    else
    begin
      freq_pick  = state.pins[0];
      phase_pick = state.pins[2:1];
    end
  end

  // [R05] offset on top bits
  // [R06] truncate to 12 bits
  // The sum wraps at 12 bits, which is exactly one cycle of offset.
  assign table_addr = 12'(state.phase_acc[31:20] + state.phase_off[phase_pick]);

  // [R07] 10-bit table output
  cos_rom u_rom
  (
    .mclk_i      (mclk_i),
    .reset_n_i   (reset_n_i),
    .addr_i      (table_addr),
    .amplitude_o (dac_code_o)
  );

  assign bus_req   = avs_read_i | avs_write_i;
  assign bus_write = avs_write_i & state.bus_ack;

  // Every access waits exactly one cycle; read data are latched in that cycle.
  assign avs_waitrequest_o = bus_req & ~state.bus_ack;
  assign avs_readdata_o    = state.readdata;

  function automatic logic [31:0] read_mux(input core_state_t s,
                                          input logic [7:0] a,
                                          input logic fp,
                                          input logic [1:0] pp,
                                          input logic [9:0] amp);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      OFS_CTRL:
      begin
        r[CTRL_SRC_POS] = s.choose_source;
      end
      OFS_STATUS:
      begin
        r[ST_FSEL_POS]                = fp;
        r[ST_PSEL_POS +: 2]           = pp;
        r[ST_FBIT_POS]                = s.freq_bit;
        r[ST_PBIT_POS +: 2]           = s.phase_bits;
        r[ST_PINS_POS +: 3]           = s.pins;
        r[ST_CMD_POS +: 4]            = s.last_cmd;
        r[ST_RSV_POS]                 = s.reserved_seen;
      end
      OFS_FREQ_A:
      begin
        r = s.freq_a;
      end
      OFS_FREQ_B:
      begin
        r = s.freq_b;
      end
      OFS_PHASE0:
      begin
        r[11:0] = s.phase_off[0];
      end
      OFS_PHASE1:
      begin
        r[11:0] = s.phase_off[1];
      end
      OFS_PHASE2:
      begin
        r[11:0] = s.phase_off[2];
      end
      OFS_PHASE3:
      begin
        r[11:0] = s.phase_off[3];
      end
      OFS_ACC:
      begin
        r = s.phase_acc;
      end
      OFS_DEFER:
      begin
        r[15:0] = s.defer;
      end
      OFS_AMP:
      begin
        r[9:0] = amp;
      end
      default:
      begin
        r = 32'h0000_0000;
      end
    endcase
    return r;
  endfunction

  always_comb
  begin
    next_state = state;

    // [R23] pins sampled on mclk
    next_state.pins = {phase_choose_hi_i, phase_choose_lo_i, freq_word_choose_i};

    // [R24] add step each clock
    // [R01] modulo 32-bit wrap
    // [R02] full range is one cycle
    // [R03] step from chosen word
    // [R04] no reload on switch
    if (freq_pick)
      next_state.phase_acc = 32'(state.phase_acc + state.freq_b);
    else
      next_state.phase_acc = 32'(state.phase_acc + state.freq_a);

    // Bus handshake: the acknowledge lasts one cycle per request.
    next_state.bus_ack = bus_req & ~state.bus_ack;
    if (bus_req && !state.bus_ack)
      next_state.readdata = read_mux(state, avs_address_i, freq_pick, phase_pick, dac_code_o);

    if (bus_write)
    begin
      if (avs_address_i == OFS_CTRL && avs_byteenable_i[0])
        next_state.choose_source = avs_writedata_i[CTRL_SRC_POS];
      // Writing one clears the reserved-code flag; a new sighting below wins.
      if (avs_address_i == OFS_STATUS && avs_byteenable_i[ST_RSV_POS / 8] &&
          avs_writedata_i[ST_RSV_POS])
        next_state.reserved_seen = 1'b0;
    end

    // [R22] act after sixteenth edge
    if (word_valid)
    begin
      next_state.last_cmd = word.cmd;
      case (word.cmd)
        // [R13] full phase write
        CMD_PHASE_FULL:
        begin
          next_state.defer                      = merged;
          next_state.phase_off[word.addr[2:1]] = merged[11:0];
        end
        // [R14] phase defer only
        CMD_PHASE_DEFER:
        begin
          next_state.defer = merged;
        end
        // [R15] half frequency write
        CMD_FREQ_FULL:
        begin
          next_state.defer = merged;
          if (word.addr[2])
          begin
            if (word.addr[1])
              next_state.freq_b[31:16] = merged;
            else
              next_state.freq_b[15:0] = merged;
          end
          else
          begin
            if (word.addr[1])
              next_state.freq_a[31:16] = merged;
            else
              next_state.freq_a[15:0] = merged;
          end
        end
        // [R16] frequency defer only
        CMD_FREQ_DEFER:
        begin
          next_state.defer = merged;
        end
        // [R17] phase choice bits
        // [R25] other fields ignored
        CMD_PSEL_BITS:
        begin
          next_state.phase_bits = {word_bits[POS_PSEL_HI], word_bits[POS_PSEL_LO]};
        end
        // [R18] frequency choice bit
        CMD_FSEL_BIT:
        begin
          next_state.freq_bit = word_bits[POS_FSEL];
        end
        // [R19] all choice bits
        CMD_BOTH_BITS:
        begin
          next_state.phase_bits = {word_bits[POS_PSEL_HI], word_bits[POS_PSEL_LO]};
          next_state.freq_bit   = word_bits[POS_FSEL];
        end
        // The test configuration is not built; the code is only flagged.
        CMD_RESERVED:
        begin
          next_state.reserved_seen = 1'b1;
        end
        default:
        begin
          next_state.defer = state.defer;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state               <= '0;
      state.phase_acc     <= ACC_RESET;
      state.freq_a        <= FREQ_RESET;
      state.freq_b        <= FREQ_RESET;
      state.phase_off     <= {4{PHASE_RESET}};
      state.defer         <= DEFER_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

endmodule
`default_nettype wire

/* hw/nco_pkg.sv */
// Shared constants and types of the oscillator core and its serial command path.
// Assumes a single 125 MHz clock and an Avalon-MM register bus of 32-bit words.
package nco_pkg;

  localparam int unsigned MCLK_HZ    = 125000000;
  localparam int unsigned ACC_W      = 32;
  localparam int unsigned PHASE_W    = 12;
  localparam int unsigned AMP_W      = 10;
  localparam int unsigned ROM_DEPTH  = 4096;
  localparam logic [4:0]  WORD_BITS  = 5'h10;

  // Command codes carried in the top nibble of a serial word.
  localparam logic [3:0] CMD_PHASE_FULL = 4'h0;
  localparam logic [3:0] CMD_PHASE_DEFER = 4'h1;
  localparam logic [3:0] CMD_FREQ_FULL  = 4'h2;
  localparam logic [3:0] CMD_FREQ_DEFER = 4'h3;
  localparam logic [3:0] CMD_PSEL_BITS  = 4'h4;
  localparam logic [3:0] CMD_FSEL_BIT   = 4'h5;
  localparam logic [3:0] CMD_BOTH_BITS  = 4'h6;
  localparam logic [3:0] CMD_RESERVED   = 4'h7;

  // Bit positions inside a 16-bit serial word.
  localparam int unsigned POS_PSEL_LO = 9;
  localparam int unsigned POS_PSEL_HI = 10;
  localparam int unsigned POS_FSEL    = 11;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FREQ_A = 8'h08;
  localparam logic [7:0] OFS_FREQ_B = 8'h0C;
  localparam logic [7:0] OFS_PHASE0 = 8'h10;
  localparam logic [7:0] OFS_PHASE1 = 8'h14;
  localparam logic [7:0] OFS_PHASE2 = 8'h18;
  localparam logic [7:0] OFS_PHASE3 = 8'h1C;
  localparam logic [7:0] OFS_ACC    = 8'h20;
  localparam logic [7:0] OFS_DEFER  = 8'h24;
  localparam logic [7:0] OFS_AMP    = 8'h28;

  // Field positions of the control and status registers.
  localparam int unsigned CTRL_SRC_POS  = 0;
  localparam int unsigned ST_FSEL_POS   = 0;
  localparam int unsigned ST_PSEL_POS   = 1;
  localparam int unsigned ST_FBIT_POS   = 3;
  localparam int unsigned ST_PBIT_POS   = 4;
  localparam int unsigned ST_PINS_POS   = 6;
  localparam int unsigned ST_CMD_POS    = 9;
  localparam int unsigned ST_RSV_POS    = 16;

  // Reset values.
  localparam logic [31:0] ACC_RESET  = 32'h0000_0000;
  localparam logic [31:0] FREQ_RESET = 32'h0000_0000;
  localparam logic [11:0] PHASE_RESET = 12'h000;
  localparam logic [15:0] DEFER_RESET = 16'h0000;
  localparam logic [9:0]  AMP_RESET  = 10'h200;

  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [7:0] data;
  } serial_word_t;

  typedef struct packed {
    logic        clk_prev;
    logic [4:0]  count;
    logic [15:0] shift;
    logic        done;
  } rx_state_t;

  typedef logic [9:0] cos_table_t [0:4095];

  typedef struct packed {
    logic [31:0]      phase_acc;
    logic [31:0]      freq_a;
    logic [31:0]      freq_b;
    logic [3:0][11:0] phase_off;
    logic [15:0]      defer;
    logic             freq_bit;
    logic [1:0]       phase_bits;
    logic             choose_source;
    logic [2:0]       pins;
    logic [3:0]       last_cmd;
    logic             reserved_seen;
    logic             bus_ack;
    logic [31:0]      readdata;
  } core_state_t;

endpackage

/* hw/cos_rom.sv */
// Cosine table: 12-bit phase address in, registered 10-bit offset-binary amplitude out.
// Table contents are built at elaboration; the read port has one clock of latency.
`timescale 1ns/1ps
`default_nettype none
module cos_rom
  import nco_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  input  wire logic [11:0] addr_i,
  output logic      [9:0]  amplitude_o
);

  function automatic cos_table_t build_table();
    cos_table_t t;
    real        ph;
    for (int i = 0; i < ROM_DEPTH; i++)
    begin
      ph   = 2.0 * 3.14159265358979 * i / ROM_DEPTH;
      t[i] = 10'(int'(511.5 + 511.5 * $cos(ph)));
    end
    return t;
  endfunction

  localparam cos_table_t TABLE = build_table();

  logic [9:0] state;
  logic [9:0] next_state;

  always_comb
  begin
    next_state = TABLE[addr_i];
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state <= AMP_RESET;
    else
      state <= next_state;
  end

  assign amplitude_o = state;

endmodule
`default_nettype wire

/* hw/serial_word_rx.sv */
// Framed 16-bit serial word receiver, bits taken on falling serial-clock edges.
// Serial pins are treated as synchronous to mclk, so the serial clock must be slower.
`timescale 1ns/1ps
`default_nettype none
module serial_word_rx
  import nco_pkg::*;
(
  input  wire logic          mclk_i,
  input  wire logic          reset_n_i,
  input  wire logic          serial_clk_i,
  input  wire logic          frame_sync_n_i,
  input  wire logic          serial_data_in_i,
  output nco_pkg::serial_word_t word_o,
  output logic               word_valid_o
);

  rx_state_t state;
  rx_state_t next_state;

  always_comb
  begin
    next_state          = state;
    next_state.done     = 1'b0;
    next_state.clk_prev = serial_clk_i;
    // [R11] any idle level
    // Only a high-to-low step counts, so a parked or running clock is harmless.
    if (frame_sync_n_i)
      next_state.count = 5'h00;
    // [R09] bit per fall
    else if (state.clk_prev && !serial_clk_i && state.count < WORD_BITS)
    begin
      // [R12] MSB first
      next_state.shift = {state.shift[14:0], serial_data_in_i};
      next_state.count = 5'(state.count + 5'h01);
      // [R08] exactly 16 bits
      next_state.done  = (state.count == 5'(WORD_BITS - 5'h01));
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state <= '0;
    else
      state <= next_state;
  end

  assign word_o       = serial_word_t'(state.shift);
  assign word_valid_o = state.done;

endmodule
`default_nettype wire

/* verif/serial_host.sv */
// Host model that writes framed words over the core's serial link.
// Assumes mclk_i is the core clock; the bench calls send() by hierarchical name.
`timescale 1ns/1ps
`default_nettype none
module serial_host
(
  input  wire logic mclk_i,
  input  wire logic park_i,
  output logic      sclk_o,
  output logic      frame_sync_n_n_o,
  output logic      serial_data_in_o
);
  initial
  begin
    sclk_o = 1'b1;
    frame_sync_n_n_o = 1'b1;
    serial_data_in_o = 1'b1;
  end
  // Levels are held two cycles because the core samples the link with mclk.
  task automatic hold();
    repeat (2) @(posedge mclk_i);
  endtask
  task automatic send(input logic [15:0] w, input int nbits);
    if (w[15:12] != 4'h7)
    begin
      frame_sync_n_n_o <= 1'b0;
      hold();
      for (int i = 15; i > 15 - nbits; i--)
      begin
        sclk_o <= 1'b1;
        serial_data_in_o <= w[i];
        hold();
        sclk_o <= 1'b0;
        hold();
      end
      frame_sync_n_n_o <= 1'b1;
      sclk_o <= park_i;
      serial_data_in_o <= ~serial_data_in_o;
      hold();
    end
  endtask
endmodule
`default_nettype wire

/* verif/nco_core_chk.sv */
// Checker for the oscillator core: shadows serial commands and compares bus reads.
// Assumes no bus read is issued while a serial frame is in flight.
`timescale 1ns/1ps
`default_nettype none
module nco_core_chk
  import nco_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        reset_n_i,
  input wire logic        serial_clk_i,
  input wire logic        frame_sync_n_i,
  input wire logic        serial_data_in_i,
  input wire logic        freq_word_choose_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o
);
  logic             sp;
  logic             pin_q;
  logic [4:0]       cnt;
  logic [15:0]      sh;
  logic [15:0]      dfr;
  logic [3:0][11:0] ph;
  logic [31:0]      fa;
  logic [31:0]      fb;
  logic             fbit;
  logic [1:0]       pb;
  logic             src;
  logic [3:0]       gap;
  logic [31:0]      last_acc;
  logic [31:0]      last_step;
  logic             fall;
  logic             ack;
  logic [15:0]      w;
  logic [15:0]      nd;
  logic [31:0]      step;
  assign fall = sp && !serial_clk_i && !frame_sync_n_i && cnt < 5'h10;
  assign ack = avs_read_i && !avs_waitrequest_o;
  assign w = {sh[14:0], serial_data_in_i};
  assign nd = w[8] ? {w[7:0], dfr[7:0]} : {dfr[15:8], w[7:0]};
  assign step = (src ? fbit : pin_q) ? fb : fa;
  // The shadow takes a word one cycle ahead of the core, so reads must not race a frame end.
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sp <= 1'b0;
      pin_q <= 1'b0;
      cnt <= 5'h00;
      sh <= 16'h0000;
      dfr <= 16'h0000;
      ph <= 48'h0;
      fa <= 32'h0;
      fb <= 32'h0;
      fbit <= 1'b0;
      pb <= 2'h0;
      src <= 1'b0;
      gap <= 4'hF;
      last_acc <= 32'h0;
      last_step <= 32'h0;
    end
    else
    begin
      sp <= serial_clk_i;
      pin_q <= freq_word_choose_i;
      cnt <= frame_sync_n_i ? 5'h00 : cnt + {4'h0, fall};
      if (fall)
        sh <= w;
      if (fall && cnt == 5'h0F && !w[15])
      begin
        if (!w[14])
          dfr <= nd;
        if (w[15:12] == CMD_PHASE_FULL)
          ph[w[10:9]] <= nd[11:0];
        if (w[15:12] == CMD_FREQ_FULL && !w[10])
          fa[{w[9], 4'h0} +: 16] <= nd;
        if (w[15:12] == CMD_FREQ_FULL && w[10])
          fb[{w[9], 4'h0} +: 16] <= nd;
        if (w[15:12] == CMD_PSEL_BITS || w[15:12] == CMD_BOTH_BITS)
          pb <= w[10:9];
        if (w[15:12] == CMD_FSEL_BIT || w[15:12] == CMD_BOTH_BITS)
          fbit <= w[11];
      end
      if (avs_write_i && !avs_waitrequest_o && avs_address_i == OFS_CTRL && avs_byteenable_i[0])
        src <= avs_writedata_i[0];
      if (ack && avs_address_i == OFS_ACC)
      begin
        gap <= 4'h0;
        last_acc <= avs_readdata_o;
        last_step <= step;
      end
      else if (gap != 4'hF)
        gap <= gap + 4'h1;
    end
  end
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);
  a_phase_regs: assert property (ack && avs_address_i[7:4] == 4'h1
    |-> avs_readdata_o == {20'h0, ph[avs_address_i[3:2]]})
    else $error("phase offset read differs from shadow");
  a_freq_a: assert property (ack && avs_address_i == OFS_FREQ_A |-> avs_readdata_o == fa)
    else $error("frequency word a differs from shadow");
  a_freq_b: assert property (ack && avs_address_i == OFS_FREQ_B |-> avs_readdata_o == fb)
    else $error("frequency word b differs from shadow");
  a_defer_reg: assert property (ack && avs_address_i == OFS_DEFER |-> avs_readdata_o == {16'h0, dfr})
    else $error("defer register differs from shadow");
  a_choice_bits: assert property (ack && avs_address_i == OFS_STATUS |-> avs_readdata_o[5:3] == {pb, fbit})
    else $error("choice bits differ from shadow");
  a_source_pick: assert property (ack && avs_address_i == OFS_STATUS
    |-> avs_readdata_o[2:0] == (src ? {pb, fbit} : avs_readdata_o[8:6]))
    else $error("effective selection ignores the source bit");
  a_ctrl_src: assert property (ack && avs_address_i == OFS_CTRL |-> avs_readdata_o[0] == src)
    else $error("source bit read differs from last write");
  a_acc_step: assert property (ack && avs_address_i == OFS_ACC && gap == 4'h2 && step == last_step
    |-> avs_readdata_o == last_acc + 32'h3 * step)
    else $error("accumulator did not advance by three steps");
  c_acc_pair: cover property (ack && avs_address_i == OFS_ACC && gap == 4'h2);
  c_src_bits: cover property (ack && avs_address_i == OFS_STATUS && src);
  c_word_done: cover property (fall && cnt == 5'h0F);
endmodule
bind nco_serial_command_core nco_core_chk nco_core_chk_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
  .serial_clk_i(serial_clk_i), .frame_sync_n_i(frame_sync_n_i), .serial_data_in_i(serial_data_in_i),
  .freq_word_choose_i(freq_word_choose_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the oscillator core: bus reads, serial commands, select pins.
// Assumes the host model in serial_host.sv and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import nco_pkg::*;
  logic        mclk_i;
  logic        reset_n_i;
  logic        park;
  logic        sclk;
  logic        frame_sync_n_n;
  logic        serial_data_in;
  logic        fpin;
  logic        plo;
  logic        phi;
  logic [7:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wreq;
  logic [9:0]  dac;
  logic [31:0] v;
  logic [31:0] a1;
  logic [31:0] a2;
  logic [11:0] off;
  int          n_errors;
  int          total_checks;
  serial_host serial_host_i (.mclk_i(mclk_i), .park_i(park), .sclk_o(sclk), .frame_sync_n_n_o(frame_sync_n_n), .serial_data_in_o(serial_data_in));
  nco_serial_command_core nco_serial_command_core_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .serial_clk_i(sclk), .frame_sync_n_i(frame_sync_n_n), .serial_data_in_i(serial_data_in), .freq_word_choose_i(fpin),
    .phase_choose_lo_i(plo), .phase_choose_hi_i(phi), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .dac_code_o(dac));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk_i);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50)
    begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, exp & m, q & m);
  endtask
  task automatic sw(input logic [15:0] w);
    serial_host_i.send(w, 16);
    repeat (4) @(posedge mclk_i);
  endtask
  initial
  begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  initial
  begin
    reset_n_i = 1'b0;
    park = 1'b1;
    fpin = 1'b0;
    plo = 1'b0;
    phi = 1'b0;
    addr = 8'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    n_errors = 0;
    total_checks = 0;
    repeat (12) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk("dac", 32'h3FF, {22'h0, dac});
    for (int i = 0; i < 4; i++)
    begin
      rdchk("phase", OFS_PHASE0 + 8'(4 * i), 32'h0, '1);
    end
    rdchk("acc", OFS_ACC, 32'h0, '1);
    rdchk("unmapped", 8'h40, 32'h0, '1);
    bus(1'b1, OFS_FREQ_A, 32'hFFFF_FFFF, v);
    rdchk("freq a", OFS_FREQ_A, 32'h0, '1);
    $display("test reset done");
    sw(16'h1B0A);
    rdchk("phase1", OFS_PHASE1, 32'h0, '1);
    rdchk("defer", OFS_DEFER, 32'h0A00, '1);
    sw(16'h0ABC);
    rdchk("phase1", OFS_PHASE1, 32'hABC, '1);
    serial_host_i.send(16'h0A55, 12);
    repeat (4) @(posedge mclk_i);
    rdchk("phase1", OFS_PHASE1, 32'hABC, '1);
    $display("test phase done");
    park <= 1'b0;
    sw(16'h3112);
    rdchk("freq a", OFS_FREQ_A, 32'h0, '1);
    sw(16'h2034);
    sw(16'h3380);
    sw(16'h2200);
    rdchk("freq a", OFS_FREQ_A, 32'h8000_1234, '1);
    bus(1'b0, OFS_ACC, 32'h0, a1);
    bus(1'b0, OFS_ACC, 32'h0, a2);
    chk("acc step", a1 + 32'h8000_1234 * 32'h3, a2);
    fpin <= 1'b1;
    repeat (3) @(posedge mclk_i);
    bus(1'b0, OFS_ACC, 32'h0, a1);
    bus(1'b0, OFS_ACC, 32'h0, a2);
    chk("acc hold", a1, a2);
    chk("acc kept", 32'h1, {31'h0, a1 != 32'h0});
    $display("test accumulator done");
    plo <= 1'b1;
    phi <= 1'b1;
    sw(16'h6D55);
    rdchk("status", OFS_STATUS, 32'hDEF, 32'h1FFF);
    bus(1'b1, OFS_CTRL, 32'h1, v);
    rdchk("status", OFS_STATUS, 32'hDED, 32'h1FFF);
    sw(16'h4BFF);
    rdchk("status", OFS_STATUS, 32'h9DB, 32'h1FFF);
    sw(16'h56AA);
    rdchk("status", OFS_STATUS, 32'hBD2, 32'h1FFF);
    $display("test select done");
    sw(16'h5800);
    bus(1'b0, OFS_ACC, 32'h0, a1);
    off = 12'h000 - a1[31:20];
    sw({12'h1B0, off[11:8]});
    sw({8'h0A, off[7:0]});
    rdchk("phase1", OFS_PHASE1, {20'h0, off}, '1);
    repeat (2) @(posedge mclk_i);
    chk("dac", 32'h3FF, {22'h0, dac});
    bus(1'b1, OFS_CTRL, 32'h0, v);
    phi <= 1'b0;
    repeat (4) @(posedge mclk_i);
    chk("dac", 32'h3FF, {22'h0, dac});
    off = off + 12'h800;
    sw({12'h1B0, off[11:8]});
    sw({8'h0A, off[7:0]});
    repeat (2) @(posedge mclk_i);
    chk("dac half", 32'h0, {22'h0, dac});
    rdchk("amp", OFS_AMP, 32'h0, '1);
    $display("test offset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
